//--- core/apm_pkg.sv
// Notes on behaviour
// - After reset the block is in normal mode with continuous acquisition.
// - The block is a register slave only; the host initiates every access.
// - Writing 1 to the deep-sleep bit at 0x11 enters suspend.
// - Suspend turns off analog, oscillator and acquisition.
// - In suspend only reads, the deep-sleep bit and soft reset act.
// - Suspend keeps the output data registers frozen at their last values.
// - Writing 1 to the reduced-power bit enters low-power mode.
// - Low-power alternates a full wake phase with an analog-off sleep phase.
// - The equidistant-select bit picks event-driven (0) or fixed-interval (1) wake.
// - The event-driven wake phase lasts for the samples the engines need.
// - A detected interrupt holds wake per its non-latched, temporary or latched mode.
// - Without interrupts, sleep follows the samples once host access ends.
// - The fixed-interval sampling period is the sleep time plus settling.
// - In fixed-interval mode the first sample after sleep goes to the FIFO.
// - A 4-bit code sets the sleep length from 0.5 ms to 1000 ms.
// - A latched interrupt clears only on writing 1 to the clear bit at 0x21 or on soft reset.
package apm_pkg;

   // ---------------------------------------------------------------
   // Clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int TICK_US = 250;
   localparam int TICK_CYC_DEF = CLK_MHZ * TICK_US;
   localparam int CNT_W = 16;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_DATA0 = 8'h02;
   localparam logic [7:0] ADDR_DATA_LAST = 8'h07;
   localparam logic [7:0] ADDR_PWR = 8'h11;
   localparam logic [7:0] ADDR_SRST = 8'h14;
   localparam logic [7:0] ADDR_IRQ = 8'h21;
   localparam logic [7:0] PWR_RESET = 8'h00;
   localparam logic [7:0] PWR_MASK = 8'hfe;
   localparam logic [7:0] SRST_KEY = 8'hb6;

   // Fields of power_mode_ctrl and irq_config_two.
   localparam int B_SUSP = 7;
   localparam int B_LOWP = 6;
   localparam int B_EQUI = 5;
   localparam int DUR_LSB = 1;
   localparam int DOZE_W = 4;
   localparam int B_IRQ_CLR = 7;
   localparam int LATCH_W = 4;
   localparam logic [LATCH_W-1:0] LATCH_NONE_A = 4'h0;
   localparam logic [LATCH_W-1:0] LATCH_NONE_B = 4'h8;
   localparam logic [LATCH_W-1:0] LATCH_HOLD_A = 4'h7;
   localparam logic [LATCH_W-1:0] LATCH_HOLD_B = 4'hf;

   // Acceleration data layout.
   localparam int AXIS_W = 12;
   localparam int LSB_W = 4;
   localparam int SMP_W = 4;

   // Sleep lengths and temporary hold times in 250 us ticks.
   localparam logic [CNT_W-1:0] DOZE_TICKS [0:15] = '{
      16'h0002, 16'h0002, 16'h0002, 16'h0002, 16'h0002, 16'h0002,
      16'h0004, 16'h0008, 16'h0010, 16'h0018, 16'h0028, 16'h0064,
      16'h00c8, 16'h0190, 16'h07d0, 16'h0fa0};
   localparam logic [CNT_W-1:0] HOLD_TICKS [0:15] = '{
      16'h0000, 16'h03e8, 16'h07d0, 16'h0fa0, 16'h1f40, 16'h3e80,
      16'h7d00, 16'h0000, 16'h0000, 16'h0001, 16'h0002, 16'h0004,
      16'h0032, 16'h0064, 16'h00c8, 16'h0000};

   typedef enum logic [1:0] {
      ST_NORMAL = 2'b00,
      ST_SUSPEND = 2'b01,
      ST_WAKE = 2'b10,
      ST_SLEEP = 2'b11
   } apm_state_e;

endpackage

//--- core/apm_doze_timer.sv
`timescale 1ns/1ns
`default_nettype none
module apm_doze_timer
   import apm_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Control
   input wire logic tick,
   input wire logic start,
   input wire logic [DOZE_W-1:0] code,
   // Status
   output logic done
);

   typedef struct packed {
      logic busy;
      logic [CNT_W-1:0] cnt;
      logic done;
   } apm_doze_s;

   apm_doze_s q;
   apm_doze_s d;

   // The first tick may come early, so a sleep can be up to one tick
   // short; this keeps a single shared divider for all timing.
   always_comb begin
      d = q;
      d.done = 1'b0;
      if (start) begin
         d.busy = 1'b1;
         d.cnt = DOZE_TICKS[code];
      end else if (q.busy && tick) begin
         if (q.cnt <= CNT_ONE) begin
            d.busy = 1'b0;
            d.done = 1'b1;
         end else begin
            d.cnt = q.cnt - CNT_ONE;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign done = q.done;

endmodule
`default_nettype wire

//--- core/apm_power_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module apm_power_ctrl
   import apm_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYC_DEF
)
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Register port from the serial front end
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic host_busy,
   // Sensor and interrupt engines
   input wire logic sample_strobe,
   input wire logic [SMP_W-1:0] samples_needed,
   input wire logic irq_cond,
   input wire logic [AXIS_W-1:0] acc_x,
   input wire logic [AXIS_W-1:0] acc_y,
   input wire logic [AXIS_W-1:0] acc_z,
   // Power and data control
   output logic analog_en,
   output logic osc_en,
   output logic acq_en,
   output logic fifo_push,
   output logic irq_latched,
   output logic [1:0] power_state
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      apm_state_e st;
      logic [7:0] pwr;
      logic [LATCH_W-1:0] latch_mode;
      logic irq_hold;
      logic [CNT_W-1:0] hold_cnt;
      logic [CNT_W-1:0] tick_cnt;
      logic [SMP_W-1:0] smp_cnt;
      logic fixed_arm;
      logic fifo_push;
      logic [3*AXIS_W-1:0] acc;
      logic [7:0] rdata;
      logic analog_en;
      logic osc_en;
      logic acq_en;
   } apm_core_s;

   localparam apm_core_s RST_Q = '{
      st: ST_NORMAL,
      pwr: PWR_RESET,
      analog_en: 1'b1,
      osc_en: 1'b1,
      acq_en: 1'b1,
      default: '0
   };
   localparam logic [CNT_W-1:0] TICK_LAST = CNT_W'(TICK_CYC - 1);

   apm_core_s q;
   apm_core_s d;
   logic tick;
   logic doze_start;
   logic doze_done;
   logic hold_clr;
   logic latched;
   logic nonlat;
   logic stay;
   logic active;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic wr_at(input logic en, input logic [7:0] a,
                                  input logic [7:0] target);
      wr_at = en && (a == target);
   endfunction

   function automatic logic [7:0] rd_mux(input logic [7:0] a,
                                         input apm_core_s s);
      logic [7:0] off;
      logic [AXIS_W-1:0] axis;
      off = a - ADDR_DATA0;
      axis = s.acc[off[2:1]*AXIS_W +: AXIS_W];
      rd_mux = 8'h00;
      if ((a >= ADDR_DATA0) && (a <= ADDR_DATA_LAST)) begin
         if (off[0]) begin
            rd_mux = axis[AXIS_W-1:LSB_W];
         end else begin
            rd_mux = {axis[LSB_W-1:0], {LSB_W{1'b0}}};
         end
      end else if (a == ADDR_PWR) begin
         rd_mux = s.pwr;
      end else if (a == ADDR_IRQ) begin
         rd_mux = {{(8-LATCH_W){1'b0}}, s.latch_mode};
      end
   endfunction

   // ---------------------------------------------------------------
   // Sleep timer
   // ---------------------------------------------------------------
   apm_doze_timer u_doze (
      .clk_sys(clk_sys),
      .rst(rst),
      .tick(tick),
      .start(doze_start),
      .code(q.pwr[DUR_LSB +: DOZE_W]),
      .done(doze_done)
   );

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      d = q;
      d.fifo_push = 1'b0;
      doze_start = 1'b0;
      active = (q.st == ST_NORMAL) || (q.st == ST_WAKE);
      // The divider stops with the oscillator in suspend.
      tick = (q.st != ST_SUSPEND) && (q.tick_cnt == TICK_LAST);
      if (q.st == ST_SUSPEND || tick) begin
         d.tick_cnt = '0;
      end else begin
         d.tick_cnt = q.tick_cnt + CNT_ONE;
      end

      // Register reads and writes; the host always starts them.
      if (reg_rd_en) begin
         d.rdata = rd_mux(reg_addr, q);
      end
      if (wr_at(reg_wr_en, reg_addr, ADDR_PWR)) begin
         if (q.st == ST_SUSPEND) begin
            d.pwr[B_SUSP] = reg_wdata[B_SUSP];
         end else begin
            d.pwr = reg_wdata & PWR_MASK;
         end
      end
      if (wr_at(reg_wr_en, reg_addr, ADDR_IRQ) && q.st != ST_SUSPEND) begin
         d.latch_mode = reg_wdata[LATCH_W-1:0];
      end

      // Interrupt hold: a new event in the clearing cycle wins.
      hold_clr = wr_at(reg_wr_en, reg_addr, ADDR_IRQ) &&
                 reg_wdata[B_IRQ_CLR] && (q.st != ST_SUSPEND);
      latched = (q.latch_mode == LATCH_HOLD_A) ||
                (q.latch_mode == LATCH_HOLD_B);
      nonlat = (q.latch_mode == LATCH_NONE_A) ||
               (q.latch_mode == LATCH_NONE_B);
      if (hold_clr) begin
         d.irq_hold = 1'b0;
      end
      if (q.irq_hold && !latched && tick) begin
         if (q.hold_cnt <= CNT_ONE) begin
            d.irq_hold = 1'b0;
         end else begin
            d.hold_cnt = q.hold_cnt - CNT_ONE;
         end
      end
      if (irq_cond && active && !nonlat) begin
         d.irq_hold = 1'b1;
         if (!q.irq_hold) begin
            d.hold_cnt = HOLD_TICKS[q.latch_mode];
         end
      end
      stay = (irq_cond && active) || q.irq_hold;

      // Samples taken in the current wake phase.
      if (q.st == ST_WAKE && sample_strobe && q.smp_cnt != '1) begin
         d.smp_cnt = q.smp_cnt + 4'h1;
      end
      // A stale arm left from an earlier fixed-interval run must not push.
      if (q.st == ST_WAKE && q.fixed_arm && q.pwr[B_EQUI] &&
          sample_strobe) begin
         d.fifo_push = 1'b1;
         d.fixed_arm = 1'b0;
      end

      // Power mode sequence; suspend outranks low-power.
      case (q.st)
         ST_NORMAL: begin
            if (q.pwr[B_SUSP]) begin
               d.st = ST_SUSPEND;
            end else if (q.pwr[B_LOWP]) begin
               d.st = ST_WAKE;
               d.smp_cnt = '0;
               d.fixed_arm = 1'b0;
            end
         end
         ST_SUSPEND: begin
            if (!q.pwr[B_SUSP]) begin
               d.st = q.pwr[B_LOWP] ? ST_WAKE : ST_NORMAL;
               d.fixed_arm = 1'b0;
               d.smp_cnt = '0;
            end
         end
         ST_WAKE: begin
            if (q.pwr[B_SUSP]) begin
               d.st = ST_SUSPEND;
            end else if (!q.pwr[B_LOWP]) begin
               d.st = ST_NORMAL;
            end else if (q.smp_cnt >= samples_needed && !stay &&
                         !host_busy) begin
               d.st = ST_SLEEP;
               doze_start = 1'b1;
            end
         end
         ST_SLEEP: begin
            if (q.pwr[B_SUSP]) begin
               d.st = ST_SUSPEND;
            end else if (!q.pwr[B_LOWP]) begin
               d.st = ST_NORMAL;
            end else if (doze_done) begin
               d.st = ST_WAKE;
               d.smp_cnt = '0;
               d.fixed_arm = q.pwr[B_EQUI];
            end
         end
         default: begin
            d.st = ST_NORMAL;
         end
      endcase

      // Output data only follows samples while acquiring.
      if (active && sample_strobe) begin
         d.acc = {acc_z, acc_y, acc_x};
      end

      if (wr_at(reg_wr_en, reg_addr, ADDR_SRST) && reg_wdata == SRST_KEY) begin
         d = RST_Q;
         doze_start = 1'b0;
      end

      d.analog_en = (d.st == ST_NORMAL) || (d.st == ST_WAKE);
      d.acq_en = d.analog_en;
      d.osc_en = (d.st != ST_SUSPEND);
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         q <= RST_Q;
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign reg_rdata = q.rdata;
   assign analog_en = q.analog_en;
   assign osc_en = q.osc_en;
   assign acq_en = q.acq_en;
   assign fifo_push = q.fifo_push;
   assign irq_latched = q.irq_hold;
   assign power_state = q.st;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_suspend_power_off: assert property (
      q.st == ST_SUSPEND |-> !analog_en && !osc_en && !acq_en)
      else $error("Power still on in suspend.");

   a_suspend_data_frozen: assert property (
      q.st == ST_SUSPEND ##1 q.st == ST_SUSPEND |-> $stable(q.acc))
      else $error("Output data changed in suspend.");

   a_suspend_entry_seq: assert property (
      q.st == ST_NORMAL && wr_at(reg_wr_en, reg_addr, ADDR_PWR) &&
      reg_wdata[B_SUSP] |=> ##1 q.st == ST_SUSPEND)
      else $error("Suspend not entered after request.");

   a_reduced_power_entry: assert property (
      q.st == ST_NORMAL && wr_at(reg_wr_en, reg_addr, ADDR_PWR) &&
      reg_wdata[B_LOWP] && !reg_wdata[B_SUSP] |=> ##1 q.st == ST_WAKE)
      else $error("Low-power not entered after request.");

   a_normal_return: assert property (
      q.st != ST_SUSPEND && wr_at(reg_wr_en, reg_addr, ADDR_PWR) &&
      !reg_wdata[B_LOWP] && !reg_wdata[B_SUSP] |=> ##1 q.st == ST_NORMAL)
      else $error("Normal mode not resumed.");

   a_irq_keeps_wake: assert property (
      q.st == ST_WAKE && irq_cond |=> q.st != ST_SLEEP)
      else $error("Slept while an interrupt held wake.");

   a_busy_keeps_wake: assert property (
      q.st == ST_WAKE && host_busy |=> q.st != ST_SLEEP)
      else $error("Slept during host access.");

   a_sleep_ends_timer: assert property (
      q.st == ST_SLEEP ##1 q.st == ST_WAKE |-> $past(doze_done))
      else $error("Sleep ended without timer expiry.");

   a_push_only_equi: assert property (
      fifo_push |-> $past(q.pwr[B_EQUI]) && $past(q.st) == ST_WAKE)
      else $error("FIFO push outside fixed-interval wake.");

   a_latch_held: assert property (
      q.irq_hold && latched && !hold_clr &&
      !wr_at(reg_wr_en, reg_addr, ADDR_SRST) |=> q.irq_hold)
      else $error("Latched interrupt cleared without request.");

   a_suspend_cfg_locked: assert property (
      q.st == ST_SUSPEND && wr_at(reg_wr_en, reg_addr, ADDR_IRQ)
      |=> $stable(q.latch_mode))
      else $error("Interrupt config written in suspend.");

   a_normal_all_on: assert property (
      q.st == ST_NORMAL |-> analog_en && osc_en && acq_en)
      else $error("Power off in normal mode.");

   a_sleep_osc_only: assert property (
      q.st == ST_SLEEP |-> !analog_en && osc_en && !acq_en)
      else $error("Wrong power in sleep phase.");

   a_data_follows: assert property (
      active && sample_strobe && !wr_at(reg_wr_en, reg_addr, ADDR_SRST)
      |=> q.acc == $past({acc_z, acc_y, acc_x}))
      else $error("Sample not stored while acquiring.");

   a_suspend_pwr_locked: assert property (
      q.st == ST_SUSPEND && wr_at(reg_wr_en, reg_addr, ADDR_PWR)
      |=> $stable(q.pwr[B_LOWP:0]))
      else $error("Mode bits written in suspend.");

   a_read_power_reg: assert property (
      reg_rd_en && reg_addr == ADDR_PWR |=> reg_rdata == $past(q.pwr))
      else $error("Power register read back wrong.");

   a_sleep_entry_timer: assert property (
      q.st == ST_SLEEP && $past(q.st) == ST_WAKE |-> $past(doze_start))
      else $error("Sleep entered without timer start.");

   c_sleep_cycle: cover property (
      q.st == ST_WAKE ##1 q.st == ST_SLEEP ##[1:1000] q.st == ST_WAKE);
   c_fifo_push: cover property (fifo_push);
   c_suspend_resume: cover property (
      q.st == ST_SUSPEND ##1 q.st == ST_NORMAL);
   c_latch_clear: cover property (q.irq_hold && latched && hold_clr);
   c_temp_hold: cover property (q.irq_hold && !latched ##1 !q.irq_hold);

endmodule
`default_nettype wire

//--- bench/apm_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module apm_host_model (
   // Clock
   input wire logic clk_sys,
   // Register port
   output logic reg_wr_en,
   output logic reg_rd_en,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   output logic host_busy
);
   initial begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      host_busy = 1'b0;
   end

   // ---------------------------------------------------------------
   // Register cycles
   // ---------------------------------------------------------------
   // The host only ever starts accesses; the block never initiates.
   // Address and data are inverted once released so that no stale value
   // can pass for a held one.
   task automatic access(input logic wr, input logic [7:0] a,
                         input logic [7:0] d, output logic [7:0] q);
      @(negedge clk_sys);
      reg_addr = a;
      reg_wdata = d;
      reg_wr_en = wr;
      reg_rd_en = !wr;
      @(negedge clk_sys);
      q = reg_rdata;
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      access(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      access(1'b0, a, 8'h00, q);
   endtask

   task automatic busy(input logic b);
      @(negedge clk_sys);
      host_busy = b;
   endtask
endmodule
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
   import apm_pkg::*;
   localparam int TC = 4;
   logic clk_sys, rst, reg_wr_en, reg_rd_en, host_busy, sample_strobe;
   logic irq_cond, analog_en, osc_en, acq_en, fifo_push, irq_latched;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
   logic [SMP_W-1:0] samples_needed;
   logic [AXIS_W-1:0] acc_x, acc_y, acc_z, sx, sy, sz;
   logic [1:0] power_state;
   logic p;
   int errors, cmp_count, seed, n, t;
   wire logic [7:0] view = {3'h0, power_state, analog_en, osc_en, acq_en};

   apm_power_ctrl #(.TICK_CYC(TC)) dut_u (.clk_sys(clk_sys), .rst(rst),
      .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .host_busy(host_busy),
      .sample_strobe(sample_strobe), .samples_needed(samples_needed),
      .irq_cond(irq_cond), .acc_x(acc_x), .acc_y(acc_y), .acc_z(acc_z),
      .analog_en(analog_en), .osc_en(osc_en), .acq_en(acq_en),
      .fifo_push(fifo_push), .irq_latched(irq_latched),
      .power_state(power_state));
   apm_host_model host_u (.clk_sys(clk_sys), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .host_busy(host_busy));

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   // ---------------------------------------------------------------
   // Expectations and checks
   // ---------------------------------------------------------------
   function automatic int doze_ticks(input int c);
      int tb_t[10] = '{4, 8, 16, 24, 40, 100, 200, 400, 2000, 4000};
      return (c < 6) ? 2 : tb_t[c-6];
   endfunction

   function automatic logic [7:0] data_byte(input int a);
      logic [AXIS_W-1:0] v;
      v = (a < 4) ? sx : ((a < 6) ? sy : sz);
      return a[0] ? v[11:4] : {v[3:0], 4'h0};
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_rng(input int got, input int lo, input int hi);
      cmp_count++;
      if (got < lo || got > hi) begin
         errors++;
         $display("CHECK FAILED t=%0t cycles %0d not in %0d..%0d",
                  $time, got, lo, hi);
      end
   endtask

   task automatic results();
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Sensor side and waits
   // ---------------------------------------------------------------
   // Samples taken while suspended must not reach the data registers,
   // so keep is low then and the expected copy stays as it was.
   task automatic strobe(input logic keep, output logic push);
      @(negedge clk_sys);
      acc_x = AXIS_W'($random(seed));
      acc_y = AXIS_W'($random(seed));
      acc_z = AXIS_W'($random(seed));
      sample_strobe = 1'b1;
      if (keep) begin
         sx = acc_x;
         sy = acc_y;
         sz = acc_z;
      end
      @(negedge clk_sys);
      push = fifo_push;
      sample_strobe = 1'b0;
      acc_x = ~acc_x;
   endtask

   task automatic wait_st(input logic [1:0] s, output int c);
      c = 0;
      while (power_state !== s && c < 20000) begin
         @(negedge clk_sys);
         c++;
      end
      if (c >= 20000) begin
         errors++;
         $display("CHECK FAILED t=%0t state %h never reached", $time, s);
      end
   endtask

   task automatic chk_data();
      for (int a = 2; a < 8; a++) begin
         host_u.rd(8'(a), q);
         chk(q, data_byte(a));
      end
   endtask

   initial begin
      #240000;
      errors++;
      results();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      seed = 32'h702d;
      errors = 0;
      cmp_count = 0;
      rst = 1'b1;
      sample_strobe = 1'b0;
      samples_needed = 4'h1;
      irq_cond = 1'b0;
      acc_x = 12'h000;
      acc_y = 12'h000;
      acc_z = 12'h000;
      repeat (12) @(negedge clk_sys);
      rst = 1'b0;
      @(negedge clk_sys);
      chk(view, 8'h07);
      host_u.rd(ADDR_PWR, q);
      chk(q, PWR_RESET);
      host_u.rd(8'h3f, q);
      chk(q, 8'h00);
      strobe(1'b1, p);
      chk_data();
      host_u.wr(ADDR_PWR, 8'h80);
      repeat (3) @(negedge clk_sys);
      chk(view, 8'h08);
      strobe(1'b0, p);
      chk_data();
      host_u.wr(ADDR_PWR, 8'hde);
      host_u.wr(ADDR_IRQ, 8'h07);
      host_u.rd(ADDR_PWR, q);
      chk(q, 8'h80);
      host_u.rd(ADDR_IRQ, q);
      chk(q, 8'h00);
      host_u.wr(ADDR_SRST, SRST_KEY);
      repeat (3) @(negedge clk_sys);
      chk(view, 8'h07);
      for (int c = 0; c < 16; c++) begin
         host_u.wr(ADDR_PWR, {2'b01, 1'b0, 4'(c), 1'b0});
         wait_st(2'b10, n);
         chk(view, 8'h17);
         strobe(1'b1, p);
         chk({7'h0, p}, 8'h00);
         wait_st(2'b11, n);
         chk_rng(n, 0, 3);
         chk(view, 8'h1a);
         wait_st(2'b10, n);
         t = doze_ticks(c);
         chk_rng(n, (t - 1) * TC, t * TC + 3);
      end
      host_u.wr(ADDR_PWR, 8'h40);
      samples_needed = 4'h3;
      repeat (2) strobe(1'b1, p);
      repeat (6) @(negedge clk_sys);
      chk(view, 8'h17);
      host_u.busy(1'b1);
      strobe(1'b1, p);
      repeat (6) @(negedge clk_sys);
      chk(view, 8'h17);
      host_u.busy(1'b0);
      wait_st(2'b11, n);
      chk_rng(n, 0, 3);
      chk_data();
      samples_needed = 4'h1;
      host_u.wr(ADDR_PWR, 8'h60);
      wait_st(2'b10, n);
      strobe(1'b1, p);
      wait_st(2'b11, n);
      wait_st(2'b10, n);
      chk_rng(n, TC, 2 * TC + 3);
      strobe(1'b1, p);
      chk({7'h0, p}, 8'h01);
      host_u.wr(ADDR_IRQ, 8'h07);
      wait_st(2'b10, n);
      irq_cond = 1'b1;
      strobe(1'b1, p);
      irq_cond = 1'b0;
      repeat (20) @(negedge clk_sys);
      chk({irq_latched, view[6:0]}, 8'h97);
      host_u.wr(ADDR_IRQ, 8'h87);
      wait_st(2'b11, n);
      chk_rng(n, 0, 4);
      chk({7'h0, irq_latched}, 8'h00);
      host_u.rd(ADDR_IRQ, q);
      chk(q, 8'h07);
      host_u.wr(ADDR_IRQ, 8'h00);
      wait_st(2'b10, n);
      irq_cond = 1'b1;
      strobe(1'b1, p);
      repeat (10) @(negedge clk_sys);
      chk(view, 8'h17);
      irq_cond = 1'b0;
      wait_st(2'b11, n);
      chk_rng(n, 0, 4);
      host_u.wr(ADDR_IRQ, 8'h0a);
      wait_st(2'b10, n);
      irq_cond = 1'b1;
      strobe(1'b1, p);
      irq_cond = 1'b0;
      chk({7'h0, irq_latched}, 8'h01);
      wait_st(2'b11, n);
      chk_rng(n, TC, 2 * TC + 3);
      host_u.wr(ADDR_PWR, 8'h00);
      wait_st(2'b00, n);
      chk_rng(n, 0, 4 * TC + 3);
      chk(view, 8'h07);
      results();
   end
endmodule
`default_nettype wire
